// file: hw/xip_seq.sv
// Sequencer that walks a quad flash controller into and out of XIP mode.
//
// Operation
// - Save mode bits before entering XIP.
// - Disable direct and indirect paths first.
// - Basic-variant family A: mode bits 0x80.
// - Family A otherwise: set flash_volatile_config bit 3.
// - Then load mode bits 0x00.
// - Family B: mode bits 0x20.
// - Family C: mode bits 0xA0.
// - Re-enable direct path, indirect if needed.
// - Exit: disable paths, restore saved mode bits.
// - Exit then clears next-read XIP bit, then re-enables direct path.
// - XIP disabled before read sequence ends.
// - Unknown power-up state: exit command, then enter.
`default_nettype none
module xip_seq
    import xip_seq_pkg::*;
(
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    input wire logic link_clk_i,
    output logic dev_req_o,
    output logic dev_we_o,
    output logic [7:0] dev_addr_o,
    output logic [31:0] dev_wdata_o,
    input wire logic dev_ack_i,
    input wire logic [31:0] dev_rdata_i
);
    // Sequence steps, one controller register access each except S_IDLE and S_DONE.
    typedef enum logic [3:0] {
        S_IDLE, S_BOOTCMD, S_RD_MODE, S_RD_CFG, S_DIS, S_VCR, S_MODE,
        S_ARM, S_REEN, S_RESTORE, S_CLRXIP, S_DONE
    } step_t;

    // Bus side state.
    logic wr_pend_reg; // A write data phase is under way.
    logic [7:0] wr_addr_reg; // Offset of that write.
    logic [31:0] rdata_reg; // Read data for the data phase.
    order_t order_reg; // Order last accepted; stable while busy.
    logic go_tgl_reg; // Flips once per accepted order with go set and an op other than the reserved value 3.
    logic busy_reg; // An order is in flight.
    logic done_reg; // Sticky: the last order finished.
    logic xip_reg; // Controller was last left with XIP armed.
    logic [7:0] saved_reg; // Mode bits saved on entry, seen by software.
    logic [31:0] devcfg_reg; // Last configuration word read back.
    logic [2:0] done_sync_reg; // Synchroniser for the done toggle.
    logic done_seen_reg; // Last done toggle value acted upon.
    logic done_evt; // One-cycle pulse when a sequence has ended.

    // Link side state.
    logic [2:0] rst_sync_reg; // Reset carried into the link domain.
    logic link_rst_reg; // Filtered link-domain reset.
    logic [2:0] go_sync_reg; // Synchroniser for the order toggle.
    logic go_seen_reg; // Last order toggle value acted upon.
    logic go_evt; // One-cycle pulse: a new order has arrived.
    step_t step_reg; // Current sequence step.
    step_t step_next; // Step after the current access completes.
    order_t lorder_reg; // Order as captured in the link domain.
    logic [7:0] lsaved_reg; // Mode bits read before entry.
    logic [31:0] cfg_reg; // Controller configuration word as read.
    logic done_tgl_reg; // Flips once per finished sequence.

    // Picks the mode-bit value for a family.
    function automatic logic [7:0] fam_mode(input fam_t f);
        case (f)
            FAM_A_BASIC: fam_mode = MODE_FAM_A_BASIC;
            FAM_A_VOLATILE: fam_mode = MODE_FAM_A_VOLATILE;
            FAM_B: fam_mode = MODE_FAM_B;
            default: fam_mode = MODE_FAM_C;
        endcase
    endfunction

    // Builds the controller access that a step performs.
    function automatic dev_acc_t step_acc(input step_t s, input order_t o,
                                          input logic [31:0] cfg, input logic [7:0] sv);
        logic [31:0] c;
        c = cfg;
        c[CFG_DIRECT_BIT] = 1'b0;
        c[CFG_INDIRECT_BIT] = 1'b0;
        step_acc = '{we: 1'b1, addr: DEV_CFG_OFS, wdata: c};
        case (s)
            S_BOOTCMD: step_acc = '{1'b1, DEV_FLASHCMD_OFS, FLASHCMD_XIP_EXIT};
            S_RD_MODE: step_acc = '{1'b0, DEV_MODEBIT_OFS, 32'h0000_0000};
            S_RD_CFG: step_acc = '{1'b0, DEV_CFG_OFS, 32'h0000_0000};
            S_VCR: step_acc = '{1'b1, DEV_FLASHCMD_OFS,
                                FLASHCMD_VCR_WRITE | (32'h0000_0001 << VCR_XIP_BIT)};
            S_MODE: step_acc = '{1'b1, DEV_MODEBIT_OFS, {24'h00_0000, fam_mode(o.fam)}};
            S_RESTORE: step_acc = '{1'b1, DEV_MODEBIT_OFS, {24'h00_0000, sv}};
            S_ARM:
            begin
                // The chosen mode bits ride after the address of each XIP read.
                if (o.imm)
                    c[CFG_XIPIMM_BIT] = 1'b1;
                else
                    c[CFG_XIPNEXT_BIT] = 1'b1;
                step_acc.wdata = c;
            end
            S_CLRXIP:
            begin
                // Next-read bit clears with both paths still off.
                c[CFG_XIPNEXT_BIT] = 1'b0;
                c[CFG_XIPIMM_BIT] = 1'b0;
                step_acc.wdata = c;
            end
            S_REEN:
            begin
                c[CFG_DIRECT_BIT] = 1'b1;
                c[CFG_INDIRECT_BIT] = o.keep_ind;
                if (o.op == OP_EXIT)
                begin
                    c[CFG_XIPNEXT_BIT] = 1'b0;
                    c[CFG_XIPIMM_BIT] = 1'b0;
                end
                else if (o.imm)
                    c[CFG_XIPIMM_BIT] = 1'b1;
                else
                    c[CFG_XIPNEXT_BIT] = 1'b1;
                step_acc.wdata = c;
            end
            default: step_acc.we = 1'b1;
        endcase
    endfunction

    // The slave never inserts wait states and never reports an error.
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign hrdata_o = rdata_reg;

    // Address phase capture; only word transfers are meaningful here.
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end
        else if (hready_i)
        begin
            wr_pend_reg <= hsel_i & htrans_i[1] & hwrite_i & (hsize_i == 3'h2);
            wr_addr_reg <= haddr_i[7:0];
        end
    end

    // Read data is registered at the address phase; unmapped offsets read zero.
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
            rdata_reg <= 32'h0000_0000;
        else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i)
        begin
            case (haddr_i[7:0])
                CTRL_OFS: rdata_reg <= {25'h0, order_reg.keep_ind, order_reg.imm,
                                        order_reg.fam, order_reg.op, 1'b0};
                STATUS_OFS: rdata_reg <= {29'h0000_0000, xip_reg, done_reg, busy_reg};
                SAVED_OFS: rdata_reg <= {24'h00_0000, saved_reg};
                DEVCFG_OFS: rdata_reg <= devcfg_reg;
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // Order acceptance. A go while busy is dropped so the order never moves
    // under the link domain, which samples it without a synchroniser.
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            order_reg <= '{OP_NONE, FAM_A_BASIC, 1'b0, 1'b0};
            go_tgl_reg <= 1'b0;
        end
        else if (wr_pend_reg && wr_addr_reg == CTRL_OFS && !busy_reg)
        begin
            order_reg <= '{op_t'(hwdata_i[CTRL_OP_LSB +: 2]), fam_t'(hwdata_i[CTRL_FAM_LSB +: 2]),
                           hwdata_i[CTRL_IMM_BIT], hwdata_i[CTRL_KEEPIND_BIT]};
            if (hwdata_i[CTRL_GO_BIT] && hwdata_i[CTRL_OP_LSB +: 2] != 2'h3)
                go_tgl_reg <= ~go_tgl_reg;
        end
    end

    // Done toggle from the link domain: three flops, second and third agree.
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            done_sync_reg <= 3'h0;
            done_seen_reg <= 1'b0;
        end
        else
        begin
            done_sync_reg <= {done_sync_reg[1:0], done_tgl_reg};
            if (done_sync_reg[1] == done_sync_reg[2])
                done_seen_reg <= done_sync_reg[2];
        end
    end
    assign done_evt = (done_sync_reg[1] == done_sync_reg[2]) &&
                      (done_sync_reg[2] != done_seen_reg);

    // Status flags. Done is set by hardware and cleared by a new go;
    // the set wins if both land together.
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            xip_reg <= 1'b0;
            saved_reg <= 8'h00;
            devcfg_reg <= 32'h0000_0000;
        end
        else if (done_evt)
        begin
            // Link-side words are stable once the done toggle has crossed.
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
            xip_reg <= (lorder_reg.op != OP_EXIT);
            saved_reg <= lsaved_reg;
            devcfg_reg <= cfg_reg;
        end
        else if (wr_pend_reg && wr_addr_reg == CTRL_OFS && !busy_reg &&
                 hwdata_i[CTRL_GO_BIT] && hwdata_i[CTRL_OP_LSB +: 2] != 2'h3)
        begin
            busy_reg <= 1'b1;
            done_reg <= 1'b0;
        end
    end

    // Reset into the link domain through three flops.
    always_ff @(posedge link_clk_i)
    begin
        rst_sync_reg <= {rst_sync_reg[1:0], reset_i};
        if (rst_sync_reg[1] == rst_sync_reg[2])
            link_rst_reg <= rst_sync_reg[2];
    end

    // Order toggle into the link domain.
    always_ff @(posedge link_clk_i)
    begin
        if (link_rst_reg)
        begin
            go_sync_reg <= 3'h0;
            go_seen_reg <= 1'b0;
        end
        else
        begin
            go_sync_reg <= {go_sync_reg[1:0], go_tgl_reg};
            if (go_sync_reg[1] == go_sync_reg[2])
                go_seen_reg <= go_sync_reg[2];
        end
    end
    assign go_evt = (go_sync_reg[1] == go_sync_reg[2]) && (go_sync_reg[2] != go_seen_reg);

    // Step order. Entry saves the mode bits and configuration first; exit
    // restores before it clears the next-read bit, and only then reopens
    // the direct path so the next read carries the exit mode bits.
    always_comb
    begin
        step_next = S_DONE;
        case (step_reg)
            S_BOOTCMD: step_next = S_RD_MODE;
            S_RD_MODE: step_next = S_RD_CFG;
            S_RD_CFG: step_next = S_DIS;
            S_DIS:
            begin
                if (lorder_reg.op == OP_EXIT)
                    step_next = S_RESTORE;
                else if (lorder_reg.fam == FAM_A_VOLATILE)
                    step_next = S_VCR;
                else
                    step_next = S_MODE;
            end
            S_VCR: step_next = S_MODE;
            S_MODE: step_next = S_ARM;
            S_ARM: step_next = S_REEN;
            S_RESTORE: step_next = S_CLRXIP;
            S_CLRXIP: step_next = S_REEN;
            S_REEN: step_next = S_DONE;
            default: step_next = S_DONE;
        endcase
    end

    // Sequencer: one register access per step, held until acknowledged.
    always_ff @(posedge link_clk_i)
    begin
        if (link_rst_reg)
        begin
            step_reg <= S_IDLE;
            lorder_reg <= '{OP_NONE, FAM_A_BASIC, 1'b0, 1'b0};
            dev_req_o <= 1'b0;
            dev_we_o <= 1'b0;
            dev_addr_o <= 8'h00;
            dev_wdata_o <= 32'h0000_0000;
            done_tgl_reg <= 1'b0;
        end
        else
        begin
            case (step_reg)
                S_IDLE:
                begin
                    if (go_evt)
                    begin
                        // Exit skips the mode save so the entry copy survives.
                        lorder_reg <= order_reg;
                        step_reg <= (order_reg.op == OP_BOOT) ? S_BOOTCMD :
                                    (order_reg.op == OP_EXIT) ? S_RD_CFG : S_RD_MODE;
                        {dev_we_o, dev_addr_o, dev_wdata_o} <= step_acc(
                            (order_reg.op == OP_BOOT) ? S_BOOTCMD :
                            (order_reg.op == OP_EXIT) ? S_RD_CFG : S_RD_MODE,
                            order_reg, cfg_reg, lsaved_reg);
                        dev_req_o <= 1'b1;
                    end
                end
                S_DONE:
                begin
                    done_tgl_reg <= ~done_tgl_reg;
                    step_reg <= S_IDLE;
                end
                default:
                begin
                    if (dev_ack_i)
                    begin
                        step_reg <= step_next;
                        dev_req_o <= (step_next != S_DONE);
                        {dev_we_o, dev_addr_o, dev_wdata_o} <= step_acc(step_next,
                            lorder_reg, (step_reg == S_RD_CFG) ? dev_rdata_i : cfg_reg,
                            lsaved_reg);
                    end
                end
            endcase
        end
    end

    // Read-back capture of mode bits and configuration word.
    always_ff @(posedge link_clk_i)
    begin
        if (link_rst_reg)
        begin
            lsaved_reg <= 8'h00;
            cfg_reg <= 32'h0000_0000;
        end
        else if (dev_ack_i && step_reg == S_RD_MODE)
            lsaved_reg <= dev_rdata_i[7:0];
        else if (dev_ack_i && step_reg == S_RD_CFG)
            cfg_reg <= dev_rdata_i;
    end
endmodule // xip_seq
`default_nettype wire

// file: hw/xip_seq_pkg.sv
// Constants and types shared by the XIP entry and exit sequencer.
`default_nettype none
package xip_seq_pkg;
    // Software-facing register byte offsets on the AHB-Lite slave.
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] SAVED_OFS = 8'h08;
    localparam logic [7:0] DEVCFG_OFS = 8'h0C;
    // Fields of the order register.
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_OP_LSB = 1;
    localparam int CTRL_FAM_LSB = 3;
    localparam int CTRL_IMM_BIT = 5;
    localparam int CTRL_KEEPIND_BIT = 6;
    // Fields of the status register.
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_DONE_BIT = 1;
    localparam int ST_XIP_BIT = 2;
    // Register offsets inside the quad flash controller.
    localparam logic [7:0] DEV_CFG_OFS = 8'h00;
    localparam logic [7:0] DEV_MODEBIT_OFS = 8'h28;
    localparam logic [7:0] DEV_FLASHCMD_OFS = 8'h90;
    // Bits of the controller configuration word.
    localparam int CFG_DIRECT_BIT = 7;
    localparam int CFG_INDIRECT_BIT = 8;
    localparam int CFG_XIPNEXT_BIT = 17;
    localparam int CFG_XIPIMM_BIT = 18;
    // Mode-bit values for each flash family.
    localparam logic [7:0] MODE_FAM_A_BASIC = 8'h80;
    localparam logic [7:0] MODE_FAM_A_VOLATILE = 8'h00;
    localparam logic [7:0] MODE_FAM_B = 8'h20;
    localparam logic [7:0] MODE_FAM_C = 8'hA0;
    // Flash command words; opcodes are plain defaults, not taken from any part.
    localparam logic [31:0] FLASHCMD_VCR_WRITE = 32'h8100_8000;
    localparam int VCR_XIP_BIT = 3;
    localparam logic [31:0] FLASHCMD_XIP_EXIT = 32'hFF00_0001;
    // Orders that software may give.
    typedef enum logic [1:0] {OP_ENTER, OP_EXIT, OP_BOOT, OP_NONE} op_t;
    // Flash families.
    typedef enum logic [1:0] {FAM_A_BASIC, FAM_A_VOLATILE, FAM_B, FAM_C} fam_t;
    // One order as it crosses into the link domain.
    typedef struct packed {
        op_t op;
        fam_t fam;
        logic imm;
        logic keep_ind;
    } order_t;
    // One access to the controller's register port.
    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [31:0] wdata;
    } dev_acc_t;
endpackage
`default_nettype wire

// file: test/qspi_ctrl_model.sv
// Behavioural model of the quad flash controller register port.
`default_nettype none
module qspi_ctrl_model
    import xip_seq_pkg::*;
(
    input wire logic link_clk_i,
    input wire logic reset_i,
    input wire logic [1:0] slow_i,
    input wire logic dev_req_i,
    input wire logic dev_we_i,
    input wire logic [7:0] dev_addr_i,
    input wire logic [31:0] dev_wdata_i,
    output logic dev_ack_o,
    output logic [31:0] dev_rdata_o
);
    logic [31:0] cfg_reg; // Controller configuration word.
    logic [7:0] mode_reg; // Mode bits sent after the address.
    logic [1:0] wait_reg; // Idle cycles spent on the current request.
    logic xip_reg; // Immediate XIP state of the controller.
    logic [31:0] val_w;
    // Read mux; unmapped offsets return zero.
    assign val_w = dev_addr_i == DEV_CFG_OFS ? cfg_reg :
        dev_addr_i == DEV_MODEBIT_OFS ? {24'h000000, mode_reg} : 32'h0000_0000;
    // Outside the ack cycle the data lines show junk, so stale data is never trusted.
    assign dev_rdata_o = dev_ack_o ? val_w : ~val_w;
    // One-cycle ack after slow_i idle cycles.
    always_ff @(posedge link_clk_i)
    begin
        if (reset_i || dev_ack_o || !dev_req_i)
        begin
            dev_ack_o <= 1'b0;
            wait_reg <= 2'h0;
        end
        else if (wait_reg >= slow_i)
            dev_ack_o <= 1'b1;
        else
            wait_reg <= wait_reg + 2'h1;
    end
    // Writes land at the ack edge. Flash reads never pass here, so the exit read
    // and the per-read framing stay latent in this model.
    always_ff @(posedge link_clk_i)
    begin
        if (reset_i)
        begin
            cfg_reg <= 32'h0000_0081;
            mode_reg <= 8'h5A;
            xip_reg <= 1'b0;
        end
        else if (dev_req_i && dev_ack_o && dev_we_i)
        begin
            if (dev_addr_i == DEV_CFG_OFS)
                cfg_reg <= dev_wdata_i;
            if (dev_addr_i == DEV_MODEBIT_OFS)
                mode_reg <= dev_wdata_i[7:0];
            if (dev_addr_i == DEV_CFG_OFS && dev_wdata_i[CFG_XIPIMM_BIT])
                xip_reg <= 1'b1;
        end
    end
endmodule // qspi_ctrl_model
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the XIP sequencer.
`default_nettype none
module tb_top
    import xip_seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] VCR_WORD = FLASHCMD_VCR_WRITE | 32'h0000_0008;
    logic mclk_i = 1'b0;
    logic link_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic hsel_i = 1'b0;
    logic hwrite_i = 1'b0;
    logic [1:0] htrans_i = 2'h0;
    logic [31:0] haddr_i = 32'h0000_0000;
    logic [31:0] hwdata_i = 32'h0000_0000;
    logic [1:0] slow = 2'h0; // Controller answer delay, varied per order.
    logic hreadyout_o, hresp_o, dev_req_o, dev_we_o, dev_ack_i;
    logic [31:0] hrdata_o, dev_wdata_o, dev_rdata_i, rd;
    logic [7:0] dev_addr_o;
    logic [31:0] m_cfg = 32'h0000_0081; // Bench copy of the controller state.
    logic [7:0] m_mode = 8'h5A;
    logic [7:0] saved = 8'h00;
    int miscompares = 0;
    int checks = 0;
    dev_acc_t exp_q[$]; // Expected controller accesses, oldest first.
    xip_seq xip_seq_inst (.mclk_i(mclk_i), .reset_i(reset_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .hrdata_o(hrdata_o), .link_clk_i(link_clk_i), .dev_req_o(dev_req_o),
        .dev_we_o(dev_we_o), .dev_addr_o(dev_addr_o), .dev_wdata_o(dev_wdata_o),
        .dev_ack_i(dev_ack_i), .dev_rdata_i(dev_rdata_i));
    qspi_ctrl_model qspi_ctrl_model_inst (.link_clk_i(link_clk_i), .reset_i(reset_i),
        .slow_i(slow), .dev_req_i(dev_req_o), .dev_we_i(dev_we_o), .dev_addr_i(dev_addr_o),
        .dev_wdata_i(dev_wdata_o), .dev_ack_o(dev_ack_i), .dev_rdata_o(dev_rdata_i));
    initial forever #5 mclk_i = ~mclk_i;
    // Link clock, phase-shifted so its edges never line up with the system clock.
    initial
    begin
        #13;
        forever #40 link_clk_i = ~link_clk_i;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // One single-word bus transfer; waits on hready.
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rdat);
        htrans_i <= 2'h2;
        hsel_i <= 1'b1;
        haddr_i <= {24'h000000, a};
        hwrite_i <= w;
        do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'h0;
        hsel_i <= 1'b0;
        hwdata_i <= wd;
        do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
        rdat = hrdata_o;
    endtask
    task automatic note(input logic w, input logic [7:0] a, input logic [31:0] d);
        exp_q.push_back('{w, a, d});
    endtask
    // Notes the accesses, gives the order, checks status.
    task automatic run_op(input op_t op, input fam_t fam, input logic imm, input logic keep);
        logic [31:0] c;
        int n;
        c = m_cfg;
        slow <= 2'($urandom);
        if (op == OP_BOOT) note(1'b1, DEV_FLASHCMD_OFS, FLASHCMD_XIP_EXIT);
        if (op != OP_EXIT) note(1'b0, DEV_MODEBIT_OFS, 32'h0);
        note(1'b0, DEV_CFG_OFS, 32'h0);
        c[CFG_DIRECT_BIT] = 1'b0;
        c[CFG_INDIRECT_BIT] = 1'b0;
        note(1'b1, DEV_CFG_OFS, c);
        if (op != OP_EXIT)
        begin
            saved = m_mode;
            if (fam == FAM_A_VOLATILE) note(1'b1, DEV_FLASHCMD_OFS, VCR_WORD);
            m_mode = fam == FAM_A_BASIC ? MODE_FAM_A_BASIC : fam == FAM_B ? MODE_FAM_B :
                fam == FAM_C ? MODE_FAM_C : MODE_FAM_A_VOLATILE;
            note(1'b1, DEV_MODEBIT_OFS, {24'h0, m_mode});
            c[imm ? CFG_XIPIMM_BIT : CFG_XIPNEXT_BIT] = 1'b1;
            note(1'b1, DEV_CFG_OFS, c);
        end
        else
        begin
            m_mode = saved;
            note(1'b1, DEV_MODEBIT_OFS, {24'h0, saved});
            c[CFG_XIPNEXT_BIT] = 1'b0;
            c[CFG_XIPIMM_BIT] = 1'b0;
            note(1'b1, DEV_CFG_OFS, c);
        end
        c[CFG_DIRECT_BIT] = 1'b1;
        c[CFG_INDIRECT_BIT] = keep;
        note(1'b1, DEV_CFG_OFS, c);
        ahb(1'b1, CTRL_OFS, {25'h0, keep, imm, fam, op, 1'b1}, rd);
        ahb(1'b0, STATUS_OFS, 32'h0, rd);
        check("busy", rd & 32'h1, 32'h1);
        // A second order while busy must be dropped; the access watcher catches extras.
        ahb(1'b1, CTRL_OFS, 32'h0000_0005, rd);
        n = 0;
        do
        begin
            ahb(1'b0, STATUS_OFS, 32'h0, rd);
            n++;
        end while (rd[ST_BUSY_BIT] !== 1'b0 && n < 600);
        check("done and xip", rd & 32'h7, op == OP_EXIT ? 32'h2 : 32'h6);
        ahb(1'b0, SAVED_OFS, 32'h0, rd);
        check("saved mode", rd & 32'hFF, {24'h0, saved});
        ahb(1'b0, DEVCFG_OFS, 32'h0, rd);
        check("device cfg", rd, m_cfg);
        check("pending accesses", 32'(exp_q.size()), 32'h0);
        m_cfg = c;
    endtask
    // Compares each finished access with the oldest note.
    always @(posedge link_clk_i)
    begin
        dev_acc_t e;
        if (dev_req_o === 1'b1 && dev_ack_i === 1'b1)
        begin
            e = exp_q.size() != 0 ? exp_q.pop_front() : '1;
            check("access", {23'h0, dev_we_o, dev_addr_o}, {23'h0, e.we, e.addr});
            if (e.we)
                check("data", dev_addr_o == DEV_MODEBIT_OFS ? {24'h0, dev_wdata_o[7:0]} :
                    dev_wdata_o, e.wdata);
        end
    end
    initial
    begin
        #400000;
        miscompares++;
        close_out();
    end
    initial
    begin
        void'($urandom(19302));
        repeat (40) @(posedge mclk_i);
        reset_i <= 1'b0;
        repeat (60) @(posedge mclk_i);
        ahb(1'b0, 8'h10, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        ahb(1'b0, CTRL_OFS, 32'h0, rd);
        check("go reads zero", rd & 32'h1, 32'h0);
        for (int f = 0; f < 4; f++)
        begin
            run_op(OP_ENTER, fam_t'(f), 1'($urandom), 1'($urandom));
            run_op(OP_EXIT, FAM_A_BASIC, 1'b0, 1'($urandom));
        end
        run_op(OP_BOOT, FAM_C, 1'b1, 1'b0);
        run_op(OP_EXIT, FAM_C, 1'b0, 1'b1);
        ahb(1'b1, CTRL_OFS, 32'h0000_0007, rd);
        repeat (100) @(posedge mclk_i);
        ahb(1'b0, STATUS_OFS, 32'h0, rd);
        check("reserved order", rd & 32'h7, 32'h2);
        close_out();
    end
endmodule // tb_top
`default_nettype wire

// file: test/xip_seq_chk.sv
// Port checker for the XIP sequencer, bound to its top module.
`default_nettype none
module xip_seq_chk
    import xip_seq_pkg::*;
(
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic link_clk_i,
    input wire logic dev_req_o,
    input wire logic dev_we_o,
    input wire logic [7:0] dev_addr_o,
    input wire logic [31:0] dev_wdata_o,
    input wire logic dev_ack_i
);
    // Command word that sets the XIP bit of flash_volatile_config.
    localparam logic [31:0] VCR_WORD = FLASHCMD_VCR_WRITE | 32'h0000_0008;
    logic done_w; // An access completes on this link edge.
    logic prev_mode_reg; // The access completed last wrote the mode bits.
    assign done_w = dev_req_o && dev_ack_i;
    // Tracks the previous access so that arm and release writes can be told apart.
    always_ff @(posedge link_clk_i)
    begin
        if (reset_i)
            prev_mode_reg <= 1'b0;
        else if (done_w)
            prev_mode_reg <= dev_we_o && (dev_addr_o == DEV_MODEBIT_OFS);
    end
    property p_hold;
        @(posedge link_clk_i) disable iff (reset_i) dev_req_o && !dev_ack_i |=>
            dev_req_o && $stable(dev_we_o) && $stable(dev_addr_o) && $stable(dev_wdata_o);
    endproperty
    a_hold: assert property (p_hold) else $error("request changed before ack");
    property p_drop;
        @(posedge link_clk_i) disable iff (reset_i) $fell(dev_req_o) |-> $past(dev_ack_i);
    endproperty
    a_drop: assert property (p_drop) else $error("request dropped without ack");
    property p_off;
        @(posedge link_clk_i) disable iff (reset_i) done_w && !dev_we_o && dev_addr_o == DEV_CFG_OFS
            |=> dev_req_o && dev_we_o && dev_addr_o == DEV_CFG_OFS
            && !dev_wdata_o[CFG_DIRECT_BIT] && !dev_wdata_o[CFG_INDIRECT_BIT];
    endproperty
    a_off: assert property (p_off) else $error("paths not switched off after cfg read");
    property p_cmd;
        @(posedge link_clk_i) disable iff (reset_i)
            dev_req_o && dev_we_o && dev_addr_o == DEV_FLASHCMD_OFS
            |-> dev_wdata_o == VCR_WORD || dev_wdata_o == FLASHCMD_XIP_EXIT;
    endproperty
    a_cmd: assert property (p_cmd) else $error("bad flash command word");
    property p_vcr;
        @(posedge link_clk_i) disable iff (reset_i) done_w && dev_addr_o == DEV_FLASHCMD_OFS
            && dev_wdata_o == VCR_WORD |=> dev_req_o && dev_we_o
            && dev_addr_o == DEV_MODEBIT_OFS && dev_wdata_o[7:0] == MODE_FAM_A_VOLATILE;
    endproperty
    a_vcr: assert property (p_vcr) else $error("mode bits not zero after config write");
    property p_mode;
        @(posedge link_clk_i) disable iff (reset_i)
            done_w && dev_we_o && dev_addr_o == DEV_MODEBIT_OFS |=> dev_req_o && dev_we_o
            && dev_addr_o == DEV_CFG_OFS && !dev_wdata_o[CFG_DIRECT_BIT]
            && !dev_wdata_o[CFG_INDIRECT_BIT];
    endproperty
    a_mode: assert property (p_mode) else $error("cfg write missing after mode bits");
    property p_cfg;
        @(posedge link_clk_i) disable iff (reset_i)
            done_w && dev_we_o && dev_addr_o == DEV_CFG_OFS && prev_mode_reg
            |=> dev_req_o && dev_we_o && dev_addr_o == DEV_CFG_OFS && dev_wdata_o[CFG_DIRECT_BIT]
            && dev_wdata_o[18:17] == $past(dev_wdata_o[18:17]);
    endproperty
    a_cfg: assert property (p_cfg) else $error("direct path not restored");
    property p_boot;
        @(posedge link_clk_i) disable iff (reset_i) done_w && dev_addr_o == DEV_FLASHCMD_OFS
            && dev_wdata_o == FLASHCMD_XIP_EXIT |=> dev_req_o && !dev_we_o
            && dev_addr_o == DEV_MODEBIT_OFS;
    endproperty
    a_boot: assert property (p_boot) else $error("entry did not follow exit command");
    c_vcr: cover property (@(posedge link_clk_i) done_w && dev_addr_o == DEV_FLASHCMD_OFS);
    c_imm: cover property (@(posedge link_clk_i) done_w && dev_wdata_o[CFG_XIPIMM_BIT]);
    c_slow: cover property (@(posedge link_clk_i) dev_req_o && !dev_ack_i [*3]);
endmodule // xip_seq_chk
bind xip_seq xip_seq_chk xip_seq_chk_inst (.mclk_i(mclk_i), .reset_i(reset_i),
    .link_clk_i(link_clk_i), .dev_req_o(dev_req_o), .dev_we_o(dev_we_o),
    .dev_addr_o(dev_addr_o), .dev_wdata_o(dev_wdata_o), .dev_ack_i(dev_ack_i));
`default_nettype wire
